// file: logic/core_memory_error_counters.sv
// ecc checking, error responses and correctable error counters of the core memories
`timescale 1ns/1ps

// How it works
// - data scratch words carry 7 check bits, checked on every access
// - single-bit data errors corrected in-line; write-back and count on retire, or at once for a dma read in a cycle with no retire write-back
// - non-speculative uncorrectable load or store raises the matching access fault
// - uncorrectable dma read of a scratch memory returns an error response
// - soc data flagged with error is discarded, never used
// - flagged soc response: fetch, load fault or store bus error nmi
// - only counts are kept, never addresses of corrected errors
// - icache counter counts tag or fetched instruction parity/ecc errors
// - threshold in 31:27, count in 26:0, interrupt when count[thresh] set
// - written threshold 27 to 31 is stored as 26
// - counter registers accept any write and read back legal values
// - reads have no side effect; writes update threshold and count together
// - interrupt is not latched; follows the selected count bit
// - count wraps at its maximum, no saturation or overflow flag
// - instr scratch counter counts correctable fetch and dma read errors
// - dma correctable errors counted in any power or halt state
// - every single-bit fetch error corrected, written back and counted
// - correctable fetch error flushes and refetches instead of in-line fix
// - several icache errors in one cycle advance the counter by one
module core_memory_error_counters import core_err_pkg::*; #(
	parameter int DS_ADDR_W = 16,
	parameter int IS_ADDR_W = 16,
	parameter int IC_WAYS = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// csr access
	input wire logic csrValid,
	input wire logic csrWrite,
	input wire logic [CSR_ADDR_W-1:0] csrAddr,
	input wire logic [31:0] csrWdata,
	output logic [31:0] csrRdata,
	output logic csrHit,
	// data scratch core access
	input wire logic dsAccValid,
	input wire logic dsAccLoad,
	input wire logic dsAccStore,
	input wire logic dsAccSpec,
	input wire logic [DS_ADDR_W-1:0] dsAccAddr,
	input wire logic [DATA_W-1:0] dsRdData,
	input wire logic [ECC_W-1:0] dsRdEcc,
	input wire logic instrRetire,
	input wire logic instrKill,
	output logic dsLoadValid,
	output logic [DATA_W-1:0] dsLoadData,
	output logic dsCountInc,
	// store path into the data scratch
	input wire logic stValid,
	input wire logic [DS_ADDR_W-1:0] stAddr,
	input wire logic [DATA_W-1:0] stData,
	output logic stReady,
	// data scratch write port
	output logic dsWrValid,
	output logic [DS_ADDR_W-1:0] dsWrAddr,
	output logic [DATA_W-1:0] dsWrData,
	output logic [ECC_W-1:0] dsWrEcc,
	// dma reads of either scratch memory
	input wire logic dmaRdValid,
	input wire logic dmaRdInstr,
	input wire logic [IS_ADDR_W-1:0] dmaRdAddr,
	input wire logic [DATA_W-1:0] dmaRdData,
	input wire logic [ECC_W-1:0] dmaRdEcc,
	output logic dmaRespValid,
	output logic [DATA_W-1:0] dmaRespData,
	output logic dmaRespError,
	// instr scratch fetch
	input wire logic isFetchValid,
	input wire logic isFetchOldest,
	input wire logic [IS_ADDR_W-1:0] isFetchAddr,
	input wire logic [DATA_W-1:0] isFetchData,
	input wire logic [ECC_W-1:0] isFetchEcc,
	output logic isFetchOkValid,
	output logic [DATA_W-1:0] isFetchOkData,
	output logic refetchFlush,
	// instr scratch write port
	output logic isWrValid,
	output logic [IS_ADDR_W-1:0] isWrAddr,
	output logic [DATA_W-1:0] isWrData,
	output logic [ECC_W-1:0] isWrEcc,
	// icache error reports
	input wire logic [IC_WAYS-1:0] icTagErr,
	input wire logic icDataErr,
	// soc memory responses
	input wire logic socRespValid,
	input wire logic socRespErr,
	input wire respKind_type socRespKind,
	input wire logic [DATA_W-1:0] socRespData,
	output logic socDataValid,
	output logic [DATA_W-1:0] socDataOut,
	// faults and interrupt
	output logic instrAccessFault,
	output logic loadAccessFault,
	output logic storeAccessFault,
	output logic storeBusErrorNmi,
	output logic corrErrIrq
);

	// ************************************************************
	// secded code: hamming bits at power-of-two positions plus overall parity
	// ************************************************************
	function automatic logic [ECC_W-1:0] eccEncode(input logic [DATA_W-1:0] d);
		logic [CODE_LEN:1] cw;
		logic [ECC_W-1:0] e;
		int j;
		cw = '0;
		e = '0;
		j = 0;
		for (int p = 1; p <= CODE_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p] = d[j];
				j++;
			end
		end
		for (int k = 0; k < HAM_W; k++) begin
			for (int p = 1; p <= CODE_LEN; p++) begin
				if (((p >> k) & 1) != 0) begin
					e[k] = e[k] ^ cw[p];
				end
			end
		end
		e[ECC_W-1] = ^{d, e[HAM_W-1:0]};
		return e;
	endfunction

	// returns {uncorrectable, corrected, data}
	function automatic logic [DATA_W+1:0] eccCheck(input logic [DATA_W-1:0] d, input logic [ECC_W-1:0] e);
		logic [CODE_LEN:1] cw;
		logic [HAM_W-1:0] syn;
		logic [DATA_W-1:0] fixed;
		logic overall;
		logic single;
		logic double;
		int j;
		cw = '0;
		syn = '0;
		fixed = '0;
		j = 0;
		for (int k = 0; k < HAM_W; k++) begin
			cw[1 << k] = e[k];
		end
		for (int p = 1; p <= CODE_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p] = d[j];
				j++;
			end
		end
		for (int k = 0; k < HAM_W; k++) begin
			for (int p = 1; p <= CODE_LEN; p++) begin
				if (((p >> k) & 1) != 0) begin
					syn[k] = syn[k] ^ cw[p];
				end
			end
		end
		overall = ^{d, e};
		// an odd flip that points past the word is really a multi-bit error
		single = overall && (int'(syn) <= CODE_LEN);
		double = (!overall && syn != '0) || (overall && !single);
		if (single && syn != '0) begin
			cw[syn] = ~cw[syn];
		end
		j = 0;
		for (int p = 1; p <= CODE_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				fixed[j] = cw[p];
				j++;
			end
		end
		return {double, single, fixed};
	endfunction

	// ************************************************************
	// checks of the three read paths
	// ************************************************************
	logic [DATA_W+1:0] dsChk;
	logic [DATA_W+1:0] dmaChk;
	logic [DATA_W+1:0] fetchChk;
	logic dsSingle;
	logic dsDouble;
	logic dmaSingle;
	logic dmaDouble;
	logic fetchSingle;
	logic fetchDouble;

	assign dsChk = eccCheck(dsRdData, dsRdEcc);
	assign dmaChk = eccCheck(dmaRdData, dmaRdEcc);
	assign fetchChk = eccCheck(isFetchData, isFetchEcc);
	assign dsSingle = dsAccValid && dsChk[DATA_W];
	assign dsDouble = dsAccValid && dsChk[DATA_W+1];
	assign dmaSingle = dmaRdValid && dmaChk[DATA_W];
	assign dmaDouble = dmaRdValid && dmaChk[DATA_W+1];
	assign fetchSingle = isFetchValid && fetchChk[DATA_W];
	assign fetchDouble = isFetchValid && fetchChk[DATA_W+1];

	// ************************************************************
	// corrected word held until its instruction retires or dies
	// ************************************************************
	logic pend_q, pend_d;
	logic [DS_ADDR_W-1:0] pendAddr_q, pendAddr_d;
	logic [DATA_W-1:0] pendData_q, pendData_d;
	logic wbCommit;
	logic dmaDsWb;

	// the held word is not written back for a killed or faulting instruction
	assign wbCommit = pend_q && instrRetire;
	assign dmaDsWb = dmaSingle && !dmaRdInstr;

	always_comb begin
		pend_d = pend_q;
		pendAddr_d = pendAddr_q;
		pendData_d = pendData_q;
		if (instrRetire || instrKill) begin
			pend_d = 1'b0;
		end
		if (dsSingle && (dsAccLoad || dsAccStore)) begin
			pend_d = 1'b1;
			pendAddr_d = dsAccAddr;
			pendData_d = dsChk[DATA_W-1:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			pendAddr_q <= '0;
			pendData_q <= '0;
		end else begin
			pend_q <= pend_d;
			pendAddr_q <= pendAddr_d;
			pendData_q <= pendData_d;
		end
	end

	// ************************************************************
	// write ports: repairs go first, stores wait through stReady
	// ************************************************************
	logic dsWrValid_q, dsWrValid_d;
	logic [DS_ADDR_W-1:0] dsWrAddr_q, dsWrAddr_d;
	logic [DATA_W-1:0] dsWrData_q, dsWrData_d;
	logic isWrValid_q, isWrValid_d;
	logic [IS_ADDR_W-1:0] isWrAddr_q, isWrAddr_d;
	logic [DATA_W-1:0] isWrData_q, isWrData_d;
	logic dsCountInc_q, dsCountInc_d;

	assign stReady = !(wbCommit || dmaDsWb);

	always_comb begin
		dsWrValid_d = 1'b0;
		dsWrAddr_d = dsWrAddr_q;
		dsWrData_d = dsWrData_q;
		isWrValid_d = 1'b0;
		isWrAddr_d = isWrAddr_q;
		isWrData_d = isWrData_q;
		if (wbCommit) begin
			dsWrValid_d = 1'b1;
			dsWrAddr_d = pendAddr_q;
			dsWrData_d = pendData_q;
		end else if (dmaDsWb) begin
			dsWrValid_d = 1'b1;
			dsWrAddr_d = DS_ADDR_W'(dmaRdAddr);
			dsWrData_d = dmaChk[DATA_W-1:0];
		end else if (stValid) begin
			dsWrValid_d = 1'b1;
			dsWrAddr_d = stAddr;
			dsWrData_d = stData;
		end
		if (fetchSingle) begin
			isWrValid_d = 1'b1;
			isWrAddr_d = isFetchAddr;
			isWrData_d = fetchChk[DATA_W-1:0];
		end else if (dmaSingle && dmaRdInstr) begin
			isWrValid_d = 1'b1;
			isWrAddr_d = dmaRdAddr;
			isWrData_d = dmaChk[DATA_W-1:0];
		end
		// the data counter lives elsewhere; only the event leaves here
		dsCountInc_d = wbCommit || dmaDsWb;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dsWrValid_q <= 1'b0;
			dsWrAddr_q <= '0;
			dsWrData_q <= '0;
			isWrValid_q <= 1'b0;
			isWrAddr_q <= '0;
			isWrData_q <= '0;
			dsCountInc_q <= 1'b0;
		end else begin
			dsWrValid_q <= dsWrValid_d;
			dsWrAddr_q <= dsWrAddr_d;
			dsWrData_q <= dsWrData_d;
			isWrValid_q <= isWrValid_d;
			isWrAddr_q <= isWrAddr_d;
			isWrData_q <= isWrData_d;
			dsCountInc_q <= dsCountInc_d;
		end
	end

	assign dsWrValid = dsWrValid_q;
	assign dsWrAddr = dsWrAddr_q;
	assign dsWrData = dsWrData_q;
	assign dsWrEcc = eccEncode(dsWrData_q);
	assign isWrValid = isWrValid_q;
	assign isWrAddr = isWrAddr_q;
	assign isWrData = isWrData_q;
	assign isWrEcc = eccEncode(isWrData_q);
	assign dsCountInc = dsCountInc_q;

	// ************************************************************
	// read results, responses and faults
	// ************************************************************
	logic [6:0] flags_q, flags_d;
	logic [DATA_W-1:0] dsLoadData_q, dsLoadData_d;
	logic [DATA_W-1:0] dmaRespData_q, dmaRespData_d;
	logic [DATA_W-1:0] isFetchOkData_q, isFetchOkData_d;
	logic [DATA_W-1:0] socDataOut_q, socDataOut_d;
	logic dsLoadValid_q, dmaRespValid_q, dmaRespError_q;
	logic isFetchOkValid_q, refetchFlush_q, socDataValid_q;
	logic socFlag;

	assign socFlag = socRespValid && socRespErr;

	always_comb begin
		flags_d = '0;
		dsLoadData_d = dsChk[DATA_W-1:0];
		dmaRespData_d = dmaChk[DATA_W-1:0];
		isFetchOkData_d = isFetchData;
		socDataOut_d = socRespData;
		flags_d[0] = dsAccValid && dsAccLoad && !dsDouble;
		flags_d[1] = (dsDouble && dsAccLoad && !dsAccSpec) || (socFlag && socRespKind == RESP_LOAD);
		flags_d[2] = dsDouble && dsAccStore && !dsAccSpec;
		flags_d[3] = (fetchDouble && isFetchOldest) || (socFlag && socRespKind == RESP_FETCH);
		flags_d[4] = socFlag && socRespKind == RESP_STORE;
		// a corrected fetch is not forwarded: the pipe refetches the repaired word
		flags_d[5] = fetchSingle;
		flags_d[6] = isFetchValid && !fetchSingle && !fetchDouble;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= '0;
			dsLoadData_q <= '0;
			dmaRespData_q <= '0;
			isFetchOkData_q <= '0;
			socDataOut_q <= '0;
			dsLoadValid_q <= 1'b0;
			dmaRespValid_q <= 1'b0;
			dmaRespError_q <= 1'b0;
			isFetchOkValid_q <= 1'b0;
			refetchFlush_q <= 1'b0;
			socDataValid_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			dsLoadData_q <= dsLoadData_d;
			dmaRespData_q <= dmaRespData_d;
			isFetchOkData_q <= isFetchOkData_d;
			socDataOut_q <= socDataOut_d;
			dsLoadValid_q <= flags_d[0];
			dmaRespValid_q <= dmaRdValid;
			dmaRespError_q <= dmaDouble;
			isFetchOkValid_q <= flags_d[6];
			refetchFlush_q <= flags_d[5];
			socDataValid_q <= socRespValid && !socRespErr;
		end
	end

	assign dsLoadValid = dsLoadValid_q;
	assign dsLoadData = dsLoadData_q;
	assign loadAccessFault = flags_q[1];
	assign storeAccessFault = flags_q[2];
	assign instrAccessFault = flags_q[3];
	assign storeBusErrorNmi = flags_q[4];
	assign refetchFlush = refetchFlush_q;
	assign isFetchOkValid = isFetchOkValid_q;
	assign isFetchOkData = isFetchOkData_q;
	assign dmaRespValid = dmaRespValid_q;
	assign dmaRespData = dmaRespData_q;
	assign dmaRespError = dmaRespError_q;
	assign socDataValid = socDataValid_q;
	assign socDataOut = socDataOut_q;

	// ************************************************************
	// counter/threshold registers; only counts are kept, no addresses
	// ************************************************************
	logic [1:0] incAmt [NUM_ECT];
	logic [NUM_ECT-1:0] irqHit;
	logic [THRESH_W-1:0] wThresh;
	logic [THRESH_W-1:0] thr_q [NUM_ECT];
	logic [COUNT_W-1:0] cnt_q [NUM_ECT];

	assign incAmt[IDX_IC] = {1'b0, (|icTagErr) || icDataErr};
	assign incAmt[IDX_IS] = 2'(fetchSingle) + 2'(dmaSingle && dmaRdInstr);
	// illegal thresholds are folded on the way in so a read never sees them
	assign wThresh = (csrWdata[THRESH_MSB:THRESH_LSB] > THRESH_LEGAL_MAX) ?
		THRESH_LEGAL_MAX : csrWdata[THRESH_MSB:THRESH_LSB];

	for (genvar g = 0; g < NUM_ECT; g++) begin : gEct
		logic [THRESH_W-1:0] thr_d;
		logic [COUNT_W-1:0] cnt_d;
		logic wrHit;
		assign wrHit = csrValid && csrWrite && csrAddr == ((g == IDX_IC) ? CSR_IC_ECT : CSR_IS_ECT);

		always_comb begin
			thr_d = thr_q[g];
			// wraps silently at the top of the field
			cnt_d = cnt_q[g] + COUNT_W'(incAmt[g]);
			if (wrHit) begin
				thr_d = wThresh;
				cnt_d = csrWdata[COUNT_MSB:0];
			end
		end

		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				thr_q[g] <= ECT_RESET[THRESH_MSB:THRESH_LSB];
				cnt_q[g] <= ECT_RESET[COUNT_MSB:0];
			end else begin
				thr_q[g] <= thr_d;
				cnt_q[g] <= cnt_d;
			end
		end

		// level straight from the count, so clearing the count drops it
		assign irqHit[g] = cnt_q[g][thr_q[g]];
	end

	assign corrErrIrq = |irqHit;

	// ************************************************************
	// csr read: registered, no side effect
	// ************************************************************
	logic [31:0] csrRdata_q, csrRdata_d;
	logic csrHit_q, csrHit_d;

	always_comb begin
		csrRdata_d = 32'h0;
		csrHit_d = 1'b0;
		if (csrValid && csrAddr == CSR_IC_ECT) begin
			csrRdata_d = {thr_q[IDX_IC], cnt_q[IDX_IC]};
			csrHit_d = 1'b1;
		end else if (csrValid && csrAddr == CSR_IS_ECT) begin
			csrRdata_d = {thr_q[IDX_IS], cnt_q[IDX_IS]};
			csrHit_d = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			csrRdata_q <= 32'h0;
			csrHit_q <= 1'b0;
		end else begin
			csrRdata_q <= csrRdata_d;
			csrHit_q <= csrHit_d;
		end
	end

	assign csrRdata = csrRdata_q;
	assign csrHit = csrHit_q;

endmodule

// file: logic/core_err_pkg.sv
// constants and types shared by the core memory error counter block
package core_err_pkg;

	// ************************************************************
	// csr map
	// ************************************************************
	localparam int CSR_ADDR_W = 12;
	localparam logic [11:0] CSR_IC_ECT = 12'h7F0;
	localparam logic [11:0] CSR_IS_ECT = 12'h7F1;
	localparam logic [31:0] ECT_RESET = 32'h0;

	// ************************************************************
	// counter/threshold field layout
	// ************************************************************
	localparam int THRESH_MSB = 31;
	localparam int THRESH_LSB = 27;
	localparam int THRESH_W = 5;
	localparam int COUNT_MSB = 26;
	localparam int COUNT_W = 27;
	localparam logic [4:0] THRESH_LEGAL_MAX = 5'h1A;
	localparam int NUM_ECT = 2;
	localparam int IDX_IC = 0;
	localparam int IDX_IS = 1;

	// ************************************************************
	// ecc word layout
	// ************************************************************
	localparam int DATA_W = 32;
	localparam int ECC_W = 7;
	localparam int HAM_W = 6;
	localparam int CODE_LEN = 38;

	// ************************************************************
	// kind of a soc memory response
	// ************************************************************
	typedef enum logic [1:0] {
		RESP_FETCH,
		RESP_LOAD,
		RESP_STORE
	} respKind_type;

endpackage

// file: dv/core_err_properties.sv
// concurrent checks on the ports of the memory error counter block
`timescale 1ns/1ps
module core_err_properties import core_err_pkg::*; #(
	parameter int IC_WAYS = 4
) (
	// clock, reset and csr
	input wire logic clock, rst_n, csrValid, csrWrite, csrHit, socDataValid,
	input wire logic [CSR_ADDR_W-1:0] csrAddr,
	input wire logic [31:0] csrRdata, socRespData, socDataOut,
	// access strobes and answers
	input wire logic dsAccValid, dsAccSpec, dsWrValid, dsCountInc, dmaRdValid, dmaRespValid, dmaRespError,
	input wire logic isFetchValid, refetchFlush, isFetchOkValid, isWrValid, icDataErr, socRespValid, socRespErr,
	input wire logic [IC_WAYS-1:0] icTagErr,
	input wire respKind_type socRespKind,
	// faults and interrupt
	input wire logic loadAccessFault, storeAccessFault, storeBusErrorNmi, corrErrIrq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic mapped;
	assign mapped = csrAddr == CSR_IC_ECT || csrAddr == CSR_IS_ECT;
	chk_csr_hit: assert property (csrValid && mapped |=> csrHit)
		else $error("mapped csr access without hit");
	chk_csr_unmapped: assert property (csrValid && !mapped |=> !csrHit && csrRdata == 32'h0)
		else $error("unmapped csr access answered");
	chk_thresh_legal: assert property (csrHit && !$past(csrWrite) |-> csrRdata[31:27] <= THRESH_LEGAL_MAX)
		else $error("illegal threshold read back");
	chk_soc_pass: assert property (socRespValid && !socRespErr |=> socDataValid && socDataOut == $past(socRespData))
		else $error("clean soc data not passed");
	chk_soc_nmi: assert property (socRespValid && socRespErr && socRespKind == RESP_STORE |=> storeBusErrorNmi && !socDataValid)
		else $error("flagged store response mishandled");
	chk_spec_quiet: assert property (dsAccValid && dsAccSpec && !socRespValid |=> !loadAccessFault && !storeAccessFault)
		else $error("fault on speculative access");
	chk_dma_answer: assert property (dmaRdValid |=> dmaRespValid)
		else $error("dma read not answered");
	chk_count_write: assert property (dsCountInc |-> dsWrValid)
		else $error("count without write back");
	chk_flush_repair: assert property (refetchFlush |-> isWrValid && !isFetchOkValid)
		else $error("refetch without repair");
	chk_irq_steady: assert property (!csrValid && icTagErr == '0 && !icDataErr && !isFetchValid && !dmaRdValid
		|=> $stable(corrErrIrq))
		else $error("interrupt moved without cause");
	cover property (refetchFlush);
	cover property (dmaRespError);
	cover property ($rose(corrErrIrq));
endmodule
bind core_memory_error_counters core_err_properties #(.IC_WAYS(IC_WAYS)) chk (.clock, .rst_n, .csrValid,
	.csrWrite, .csrHit, .csrAddr, .csrRdata, .socRespData, .socDataOut, .dsAccValid, .dsAccSpec, .dsWrValid,
	.dsCountInc, .dmaRdValid, .dmaRespValid, .dmaRespError, .isFetchValid, .refetchFlush, .isFetchOkValid,
	.isWrValid, .icDataErr, .socRespValid, .socRespErr, .icTagErr, .socRespKind, .loadAccessFault,
	.storeAccessFault, .storeBusErrorNmi, .corrErrIrq, .socDataValid);

// file: dv/soc_mem_model.sv
// behavioural soc memory answering with corrected or flagged data
`timescale 1ns/1ps
module soc_mem_model import core_err_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// request: 0 clean, 1 single-bit, 2 uncorrectable
	input wire logic reqValid,
	input wire logic [1:0] reqErr,
	input wire logic reqSlow,
	input wire respKind_type reqKind,
	// response towards the core
	output logic socRespValid,
	output logic socRespErr,
	output respKind_type socRespKind,
	output logic [31:0] socRespData,
	output logic extIrq
);
	logic [1:0] waitQ, codeQ;
	logic [3:0] fixQ;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{waitQ, codeQ, fixQ, socRespValid, socRespErr} <= '0;
			socRespKind <= RESP_FETCH;
			socRespData <= 32'h0;
		end else begin
			socRespValid <= waitQ == 2'h1;
			socRespErr <= waitQ == 2'h1 && codeQ == 2'h2;
			// idle bus toggles so stale data never passes for an answer
			socRespData <= waitQ != 2'h1 ? ~socRespData : codeQ == 2'h2 ? 32'hBAD0BAD0 : 32'h00C0FFEE;
			waitQ <= reqValid ? (reqSlow ? 2'h2 : 2'h1) : (waitQ != 2'h0 ? waitQ - 2'h1 : waitQ);
			if (reqValid) begin
				codeQ <= reqErr;
				socRespKind <= reqKind;
			end
			if (waitQ == 2'h1 && codeQ == 2'h1) begin
				fixQ <= fixQ + 4'h1;
			end
		end
	end
	// threshold of the local counter is a plain choice
	assign extIrq = fixQ >= 4'h4;
endmodule

// file: dv/core_memory_error_counters_tb.sv
// self-checking bench for the memory error counter block
`timescale 1ns/1ps
module core_memory_error_counters_tb import core_err_pkg::*; ;
	typedef struct packed {
		logic [2:0] sel;
		logic [31:0] flip;
		logic [1:0] aux;
		logic [9:0] expOut;
		logic [31:0] expData;
	} row_type;
	// sel 0 load, 1 store, 2 fetch, 3 dma, 4 soc (flip[1:0] code, flip[2] slow)
	localparam row_type ROWS [16] = '{'{0, 0, 0, 10'h200, 0}, '{0, 32'h100, 0, 10'h200, 0},
		'{0, 3, 0, 10'h004, 0}, '{0, 3, 1, 10'h000, 0}, '{1, 3, 0, 10'h002, 0}, '{2, 0, 1, 10'h080, 0},
		'{2, 32'h80000000, 1, 10'h100, 0}, '{2, 3, 1, 10'h008, 0}, '{2, 3, 0, 10'h000, 0},
		'{3, 32'h30000, 0, 10'h060, 0}, '{3, 32'h10, 1, 10'h040, 0}, '{4, 2, 0, 10'h008, 0},
		'{4, 2, 1, 10'h004, 0}, '{4, 2, 2, 10'h001, 0}, '{4, 5, 1, 10'h010, 32'h00C0FFEE},
		'{4, 0, 2, 10'h010, 32'h00C0FFEE}};
	logic clock, rst_n, csrValid, csrWrite, csrHit, dsAccValid, dsAccLoad, dsAccStore, dsAccSpec, instrRetire;
	logic instrKill, dsLoadValid, dsCountInc, stValid, stReady, dsWrValid, dmaRdValid, dmaRdInstr, dmaRespValid;
	logic dmaRespError, isFetchValid, isFetchOldest, isFetchOkValid, refetchFlush, isWrValid, icDataErr;
	logic socRespValid, socRespErr, socDataValid, instrAccessFault, loadAccessFault, storeAccessFault;
	logic storeBusErrorNmi, corrErrIrq, reqValid, reqSlow, extIrq, hit;
	logic [1:0] reqErr;
	logic [3:0] icTagErr;
	logic [6:0] dsRdEcc, dsWrEcc, dmaRdEcc, isFetchEcc, isWrEcc;
	logic [9:0] outs;
	logic [11:0] csrAddr;
	logic [15:0] dsAccAddr, stAddr, dsWrAddr, dmaRdAddr, isFetchAddr, isWrAddr;
	logic [31:0] csrWdata, csrRdata, dsRdData, dsLoadData, stData, dsWrData, dmaRdData, dmaRespData, rd;
	logic [31:0] isFetchData, isFetchOkData, isWrData, socRespData, socDataOut;
	respKind_type socRespKind, reqKind;
	int errTotal, samplesChecked, cycles;
	assign outs = {dsLoadValid, refetchFlush, isFetchOkValid, dmaRespValid, dmaRespError, socDataValid,
		instrAccessFault, loadAccessFault, storeAccessFault, storeBusErrorNmi};
	core_memory_error_counters dut (.clock, .rst_n, .csrValid, .csrWrite, .csrAddr, .csrWdata, .csrRdata, .csrHit,
		.dsAccValid, .dsAccLoad, .dsAccStore, .dsAccSpec, .dsAccAddr, .dsRdData, .dsRdEcc, .instrRetire, .instrKill,
		.dsLoadValid, .dsLoadData, .dsCountInc, .stValid, .stAddr, .stData, .stReady, .dsWrValid, .dsWrAddr,
		.dsWrData, .dsWrEcc, .dmaRdValid, .dmaRdInstr, .dmaRdAddr, .dmaRdData, .dmaRdEcc, .dmaRespValid,
		.dmaRespData, .dmaRespError, .isFetchValid, .isFetchOldest, .isFetchAddr, .isFetchData, .isFetchEcc,
		.isFetchOkValid, .isFetchOkData, .refetchFlush, .isWrValid, .isWrAddr, .isWrData, .isWrEcc, .icTagErr,
		.icDataErr, .socRespValid, .socRespErr, .socRespKind, .socRespData, .socDataValid, .socDataOut,
		.instrAccessFault, .loadAccessFault, .storeAccessFault, .storeBusErrorNmi, .corrErrIrq);
	soc_mem_model partner (.clock, .rst_n, .reqValid, .reqErr, .reqSlow, .reqKind, .socRespValid, .socRespErr,
		.socRespKind, .socRespData, .extIrq);
	task automatic closeOut();
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		samplesChecked++;
		if (seen !== want) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic step();
		@(posedge clock);
		#1;
	endtask
	task automatic csr(input logic wr, input logic [11:0] a, input logic [31:0] d);
		step();
		{csrValid, csrWrite, csrAddr, csrWdata} = {1'b1, wr, a, d};
		step();
		csrValid = 1'b0;
		rd = csrRdata;
		hit = csrHit;
	endtask
	// one cycle of error reports; check-bit flips on clean zero words
	task automatic errs(input logic [3:0] tag, input logic dat, input logic fetch, input logic dma);
		step();
		{icTagErr, icDataErr, isFetchValid, isFetchOldest, isFetchEcc} = {tag, dat, fetch, 1'b1, 7'h01};
		{dmaRdValid, dmaRdInstr, dmaRdEcc, dmaRdData, isFetchData} = {dma, 1'b1, 7'h04, 64'h0};
		step();
		{icTagErr, icDataErr, isFetchValid, dmaRdValid, isFetchEcc, dmaRdEcc} = '0;
	endtask
	task automatic held(input logic keep);
		step();
		{dsAccValid, dsAccLoad, dsAccStore, dsAccSpec, dsRdEcc, dsRdData} = {4'b1100, 7'h02, 32'h0};
		step();
		{dsAccValid, instrRetire, instrKill, dsRdEcc} = {1'b0, keep, !keep, 7'h00};
		step();
		{instrRetire, instrKill} = 2'h0;
		check("write back", {dsWrValid, dsCountInc, dsWrEcc, dsWrData[22:0]}, keep ? 32'hC0000000 : 32'h0);
	endtask
	task automatic runRow(input row_type r);
		logic [31:0] seen;
		step();
		case (r.sel)
			3'h0, 3'h1: begin
				{dsAccValid, dsAccLoad, dsAccStore, dsAccSpec} = {1'b1, r.sel == 3'h0, r.sel == 3'h1, r.aux[0]};
				dsRdData = r.flip;
			end
			3'h2: begin
				{isFetchValid, isFetchOldest, isFetchData} = {1'b1, r.aux[0], r.flip};
			end
			3'h3: begin
				{dmaRdValid, dmaRdInstr, dmaRdData} = {1'b1, r.aux[0], r.flip};
			end
			default: begin
				{reqValid, reqErr, reqSlow} = {1'b1, r.flip[1:0], r.flip[2]};
				reqKind = respKind_type'(r.aux);
			end
		endcase
		step();
		{dsAccValid, isFetchValid, dmaRdValid, reqValid} = 4'h0;
		for (int k = 0; k < 6 && outs == 10'h0; k++) begin
			step();
		end
		check("outputs", {22'h0, outs}, {22'h0, r.expOut});
		seen = r.sel < 3'h2 ? dsLoadData : r.sel == 3'h2 ? isFetchOkData : r.sel == 3'h3 ? dmaRespData : socDataOut;
		if ((r.expOut & 10'h2D0) != 10'h0 && !r.expOut[5]) begin
			check("data", seen, r.expData);
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			errTotal++;
			closeOut();
		end
	end
	initial begin
		rst_n = 1'b0;
		{csrValid, csrWrite, dsAccValid, dsAccLoad, dsAccStore, dsAccSpec, instrRetire, instrKill, stValid} = '0;
		{dmaRdValid, dmaRdInstr, isFetchValid, isFetchOldest, icDataErr, reqValid, reqSlow, reqErr, icTagErr} = '0;
		{csrAddr, csrWdata, dsAccAddr, stAddr, stData, dsRdData, dmaRdAddr, dmaRdData, isFetchAddr} = '0;
		{isFetchData, dsRdEcc, dmaRdEcc, isFetchEcc} = '0;
		reqKind = RESP_FETCH;
		repeat (4) @(posedge clock);
		#1 rst_n = 1'b1;
		foreach (ROWS[i]) begin
			runRow(ROWS[i]);
		end
		// second reset in mid-run, then register reset values
		rst_n = 1'b0;
		repeat (2) step();
		rst_n = 1'b1;
		csr(1'b0, CSR_IC_ECT, 32'h0);
		check("ic reset", rd, ECT_RESET);
		check("ic hit", {31'h0, hit}, 32'h1);
		csr(1'b0, CSR_IS_ECT, 32'h0);
		check("is reset", rd, ECT_RESET);
		csr(1'b1, 12'h7F2, 32'hFFFFFFFF);
		check("unmapped", rd | {31'h0, hit}, 32'h0);
		csr(1'b1, CSR_IC_ECT, 32'hF8000005);
		csr(1'b0, CSR_IC_ECT, 32'h0);
		check("thresh map", rd, 32'hD0000005);
		csr(1'b1, CSR_IC_ECT, 32'h18000007);
		check("irq below", {31'h0, corrErrIrq}, 32'h0);
		errs(4'hF, 1'b1, 1'b0, 1'b0);
		check("irq at", {31'h0, corrErrIrq}, 32'h1);
		csr(1'b0, CSR_IC_ECT, 32'h0);
		check("one step", rd, 32'h18000008);
		csr(1'b1, CSR_IC_ECT, 32'h0);
		check("irq clear", {31'h0, corrErrIrq}, 32'h0);
		csr(1'b1, CSR_IS_ECT, 32'h07FFFFFF);
		check("irq max", {31'h0, corrErrIrq}, 32'h1);
		errs(4'h0, 1'b0, 1'b1, 1'b0);
		check("irq wrap", {31'h0, corrErrIrq}, 32'h0);
		check("is repair", {isWrValid, isWrEcc, isWrData[23:0]}, 32'h80000000);
		errs(4'h0, 1'b0, 1'b1, 1'b1);
		csr(1'b0, CSR_IS_ECT, 32'h0);
		check("two sources", rd, 32'h2);
		held(1'b1);
		held(1'b0);
		step();
		{stValid, stAddr} = {1'b1, 16'h0005};
		step();
		stValid = 1'b0;
		check("store", {dsWrValid, dsWrEcc, 8'h0, dsWrAddr}, 32'h80000005);
		closeOut();
	end
endmodule
